/* File: logic/ssl_map.svh */
// Purpose: constants for the supply supervisor low-power control block
// Assumes: 200 MHz core clock, period 5 ns
// Notes: times are kept in ns, cycle counts derived from them
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH

`define SSL_CLK_PERIOD_NS 5
`define SSL_SETTLE_FAST_NS 2000
`define SSL_SETTLE_SLOW_NS 150000
// least times round up to whole cycles
`define SSL_SETTLE_FAST_CYC ((`SSL_SETTLE_FAST_NS + `SSL_CLK_PERIOD_NS - 1) / `SSL_CLK_PERIOD_NS)
`define SSL_SETTLE_SLOW_CYC ((`SSL_SETTLE_SLOW_NS + `SSL_CLK_PERIOD_NS - 1) / `SSL_CLK_PERIOD_NS)
`define SSL_WAKE_SLOW_NS 150000
`define SSL_WAKE_SLOW_CYC ((`SSL_WAKE_SLOW_NS + `SSL_CLK_PERIOD_NS - 1) / `SSL_CLK_PERIOD_NS)
`define SSL_CNT_W 16

`endif

/* File: logic/ssl_pkg.sv */
// Purpose: types for the supply supervisor low-power control block
// Assumes: nothing beyond the map header
// Notes: control words are packed structs, one per supply side
package ssl_pkg;
    typedef enum logic [1:0] {SSL_OFF, SSL_NORMAL, SSL_FULL} ssl_state_e;

    typedef struct packed {
        logic auto_ctl;
        logic sup_en;
        logic sup_keep;
        logic sup_fp;
        logic mon_en;
        logic mon_fp;
        logic overvolt_en;
    } ssl_hi_ctl_s;

    typedef struct packed {
        logic auto_ctl;
        logic sup_en;
        logic sup_keep;
        logic sup_fp;
        logic mon_en;
        logic mon_fp;
        logic ev_reset;
    } ssl_lo_ctl_s;
endpackage : ssl_pkg

/* File: logic/ssl_supervisor_ctl.sv */
// Purpose: supervisor/monitor state control, settling delays, wakeup speed and event routing
// Assumes: control words written by firmware with a one-cycle write strobe; i_lowpower high in LPM2/3/4
// Notes: analog comparators sit outside; this block only enables them and routes their trips
`include "ssl_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// - control write raises settling flags; software waits
// - some high settings turn off in lowpower
// - low full-perf clear selects 150us slow wakeup
// - overvoltage enable makes monitor trip reset
// - high auto control idles monitor in lowpower
// - low settle delay 2us full, 150us normal
module ssl_supervisor_ctl
    import ssl_pkg::*;
#(
    parameter int FAST_CYC = `SSL_SETTLE_FAST_CYC,
    parameter int SLOW_CYC = `SSL_SETTLE_SLOW_CYC,
    parameter int WAKE_CYC = `SSL_WAKE_SLOW_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hi_wr,
    input wire ssl_hi_ctl_s i_hi_ctl,
    input wire logic i_lo_wr,
    input wire ssl_lo_ctl_s i_lo_ctl,
    input wire logic i_lowpower,
    input wire logic i_wake_req,
    input wire logic i_hi_sup_trip,
    input wire logic i_hi_mon_trip,
    input wire logic i_lo_sup_trip,
    input wire logic i_lo_mon_trip,
    output logic o_hi_settle_delay_flag,
    output logic o_lo_settle_delay_flag,
    output ssl_state_e o_hi_sup_state,
    output ssl_state_e o_hi_mon_state,
    output ssl_state_e o_lo_sup_state,
    output ssl_state_e o_lo_mon_state,
    output logic o_slow_wakeup,
    output logic o_wake_done,
    output logic o_por,
    output logic o_lo_irq,
    output logic o_affected_config_check
);
    localparam int CW = `SSL_CNT_W;

    // supervisor/monitor state from enable, keep, perf and auto bits
    // one decode for every unit keeps the four state tables from drifting apart
    function automatic ssl_state_e sv_state(input logic en, input logic keep, input logic fp,
                                            input logic auto_c, input logic lp);
        if (!en)
            return SSL_OFF;
        if (!lp)
            return fp ? SSL_FULL : SSL_NORMAL;
        if (!keep)
            return SSL_OFF;
        if (auto_c)
            return fp ? SSL_NORMAL : SSL_OFF; // auto degrades full to normal
        return fp ? SSL_FULL : SSL_NORMAL;
    endfunction : sv_state

    ssl_hi_ctl_s hi_q;
    ssl_lo_ctl_s lo_q;
    logic [CW-1:0] hi_cnt_q, lo_cnt_q, wake_cnt_q;
    logic waking_q;

    // control words take effect on their write strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hi_q <= '0;
            lo_q <= '0;
        end else begin
            if (i_hi_wr) hi_q <= i_hi_ctl;
            if (i_lo_wr) lo_q <= i_lo_ctl;
        end
    end

    // state decode; monitors pass keep as 1, the high monitor is forced off by auto control in lowpower
    wire ssl_state_e hi_sup_d = sv_state(hi_q.sup_en, hi_q.sup_keep, hi_q.sup_fp, hi_q.auto_ctl, i_lowpower);
    wire ssl_state_e hi_mon_d = (hi_q.auto_ctl && i_lowpower) ? SSL_OFF
                              : sv_state(hi_q.mon_en, 1'b1, hi_q.mon_fp, 1'b0, i_lowpower);
    wire ssl_state_e lo_sup_d = sv_state(lo_q.sup_en, lo_q.sup_keep, lo_q.sup_fp, lo_q.auto_ctl, i_lowpower);
    wire ssl_state_e lo_mon_d = sv_state(lo_q.mon_en, 1'b1, lo_q.mon_fp, lo_q.auto_ctl, i_lowpower);

    // settling length picked from the perf bit being written
    // the new word sets the length, so raising the core level in normal mode gets the long wait
    wire [CW-1:0] lo_len = i_lo_ctl.sup_fp ? CW'(FAST_CYC) : CW'(SLOW_CYC);
    wire [CW-1:0] hi_new = i_hi_ctl.sup_fp ? CW'(FAST_CYC) : CW'(SLOW_CYC);

    // slow wakeup whenever a low-side unit is enabled with its full-perf bit clear, whatever its decoded state
    wire slow_d = (lo_q.sup_en && !lo_q.sup_fp) || (lo_q.mon_en && !lo_q.mon_fp);

    // either low unit off or in full-perf, combined with high normal-to-off transition
    wire lo_fast = !lo_q.sup_en || lo_q.sup_fp || !lo_q.mon_en || lo_q.mon_fp;
    wire hi_sup_hit = hi_q.sup_en && !hi_q.sup_fp && (!hi_q.sup_keep || hi_q.auto_ctl);
    wire hi_mon_hit = hi_q.mon_en && !hi_q.mon_fp && hi_q.auto_ctl;
    wire check_d = lo_fast && (hi_sup_hit || hi_mon_hit);

    // trips only count from units that are running
    // a trip from a unit that is off is analog noise, routing it would give false resets
    wire hi_sup_ev = i_hi_sup_trip && (hi_sup_d != SSL_OFF);
    wire hi_mon_ev = i_hi_mon_trip && (hi_mon_d != SSL_OFF);
    wire lo_ev = (i_lo_sup_trip && lo_sup_d != SSL_OFF) || (i_lo_mon_trip && lo_mon_d != SSL_OFF);
    wire por_d = hi_sup_ev || (hi_mon_ev && hi_q.overvolt_en) || (lo_ev && lo_q.ev_reset);
    wire irq_d = lo_ev && !lo_q.ev_reset;

    // settling counters; a new write restarts the delay
    // a write always wins over the countdown, so a later write reloads the wait with the length its own perf bit picks
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hi_cnt_q <= '0;
            lo_cnt_q <= '0;
        end else begin
            if (i_hi_wr) hi_cnt_q <= hi_new;
            else if (hi_cnt_q != '0) hi_cnt_q <= hi_cnt_q - CW'(1);
            if (i_lo_wr) lo_cnt_q <= lo_len;
            else if (lo_cnt_q != '0) lo_cnt_q <= lo_cnt_q - CW'(1);
        end
    end

    // wakeup timer: slow mode holds the done pulse back by the slow wake time
    // limitation: a wake request while a slow wake runs is ignored, the running one finishes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            waking_q <= 1'b0;
            wake_cnt_q <= '0;
            o_wake_done <= 1'b0;
        end else begin
            o_wake_done <= 1'b0;
            if (i_wake_req && !waking_q) begin
                waking_q <= slow_d;
                wake_cnt_q <= slow_d ? CW'(WAKE_CYC) : '0;
                o_wake_done <= !slow_d;
            end else if (waking_q) begin
                if (wake_cnt_q == CW'(1)) begin
                    waking_q <= 1'b0;
                    o_wake_done <= 1'b1;
                end
                wake_cnt_q <= wake_cnt_q - CW'(1);
            end
        end
    end

    // registered outputs; every pin comes straight from a flop, one cycle after its cause
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hi_settle_delay_flag <= 1'b0;
            o_lo_settle_delay_flag <= 1'b0;
            o_hi_sup_state <= SSL_OFF;
            o_hi_mon_state <= SSL_OFF;
            o_lo_sup_state <= SSL_OFF;
            o_lo_mon_state <= SSL_OFF;
            o_slow_wakeup <= 1'b0;
            o_por <= 1'b0;
            o_lo_irq <= 1'b0;
            o_affected_config_check <= 1'b0;
        end else begin
            o_hi_settle_delay_flag <= i_hi_wr || (hi_cnt_q > CW'(1));
            o_lo_settle_delay_flag <= i_lo_wr || (lo_cnt_q > CW'(1));
            o_hi_sup_state <= hi_sup_d;
            o_hi_mon_state <= hi_mon_d;
            o_lo_sup_state <= lo_sup_d;
            o_lo_mon_state <= lo_mon_d;
            o_slow_wakeup <= slow_d;
            o_por <= por_d;
            o_lo_irq <= irq_d;
            o_affected_config_check <= check_d;
        end
    end

    // checks; triggered from the inputs as well, they check registered outputs and internal state
    // settling flags and lengths
    hi_flag_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_hi_wr |=> o_hi_settle_delay_flag) else $error("high settle flag not raised");
    lo_flag_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_lo_wr && i_lo_ctl.sup_fp |=> o_lo_settle_delay_flag [*2]) else $error("low settle flag short");
    lo_fast_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_lo_wr && i_lo_ctl.sup_fp |=> lo_cnt_q == CW'(FAST_CYC)) else $error("low fast settle length wrong");
    lo_slow_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_lo_wr && !i_lo_ctl.sup_fp |=> lo_cnt_q == CW'(SLOW_CYC)) else $error("low slow settle length wrong");
    hi_fast_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_hi_wr && i_hi_ctl.sup_fp |=> hi_cnt_q == CW'(FAST_CYC)) else $error("high fast settle length wrong");
    // state decode and config check
    hi_off_lp_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_lowpower && !hi_q.sup_keep |=> o_hi_sup_state == SSL_OFF) else $error("high supervisor not off");
    hi_auto_deg_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_lowpower && hi_q.sup_en && hi_q.sup_keep && hi_q.sup_fp && hi_q.auto_ctl
        |=> o_hi_sup_state == SSL_NORMAL) else $error("auto degrade wrong");
    hi_mon_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_lowpower && hi_q.auto_ctl |=> o_hi_mon_state == SSL_OFF) else $error("monitor active in lowpower");
    cfg_check_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_affected_config_check |-> $past(lo_fast)) else $error("config check wrong");
    // event routing and wakeup
    overvolt_por_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        hi_q.overvolt_en && i_hi_mon_trip && hi_mon_d != SSL_OFF |=> o_por) else $error("overvoltage trip no reset");
    lo_route_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_lo_irq |-> !$past(lo_q.ev_reset)) else $error("low event routed wrong");
    lo_irq_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_lo_sup_trip && lo_sup_d != SSL_OFF && !lo_q.ev_reset |=> o_lo_irq) else $error("low event lost");
    slow_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        lo_q.sup_en && !lo_q.sup_fp |=> o_slow_wakeup) else $error("slow wakeup not selected");
    slow_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wake_req && !waking_q && slow_d |=> !o_wake_done [*8]) else $error("slow wakeup too quick");
    fast_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wake_req && !waking_q && !slow_d |=> o_wake_done) else $error("fast wakeup late");

    // main scenarios the bench should reach
    cov_wr_c: cover property (@(posedge i_clk) (i_lo_wr && i_lo_ctl.sup_fp) ##1 o_lo_settle_delay_flag
        ##[1:1000] !o_lo_settle_delay_flag);
    cov_por_c: cover property (@(posedge i_clk) o_por);
    cov_irq_c: cover property (@(posedge i_clk) o_lo_irq);
    cov_slow_c: cover property (@(posedge i_clk) o_wake_done && o_slow_wakeup);
    cov_auto_lp_c: cover property (@(posedge i_clk) i_lowpower && hi_q.auto_ctl && hi_q.mon_en);
endmodule : ssl_supervisor_ctl

`default_nettype wire

/* File: test/ssl_fw_model.sv */
// Purpose: firmware and power-mode sequencer stand-in driving low-power entry
// Assumes: bench requests entry; settle flags come from the block
// Notes: entry is held off while either settle flag is up, as firmware must do
`timescale 1ns/1ps
`default_nettype none
module ssl_fw_model #(
    parameter int TMO_CYC = 60000
) (
    input wire logic i_clk,
    input wire logic i_enter_req,
    input wire logic i_hi_flag,
    input wire logic i_lo_flag,
    output logic o_lowpower
);
    int wait_cnt = 0;
    logic gave_up = 1'b0;
    initial o_lowpower = 1'b0;
    // a late flag only delays entry; leaving low power is never held back
    // polling gives up after the timeout, so a flag that never clears cannot hang firmware
    always @(negedge i_clk) begin
        if (!i_enter_req) begin
            wait_cnt <= 0;
            gave_up <= 1'b0;
        end else if (!o_lowpower && (i_hi_flag || i_lo_flag) && !gave_up) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == TMO_CYC - 1) gave_up <= 1'b1;
        end
        o_lowpower <= i_enter_req & ~gave_up & (o_lowpower | (~i_hi_flag & ~i_lo_flag));
    end
endmodule : ssl_fw_model
`default_nettype wire

/* File: test/supply_supervisor_lowpower_control_tb_top.sv */
// Purpose: random self-checking bench for the supervisor control block
// Assumes: short settle and wake counts 4, 20, 20
// Notes: expectations come from the state tables, not from the design
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_lowpower_control_tb_top;
    import ssl_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, hw = 1'b0, lw = 1'b0, ent = 1'b0, wk = 1'b0;
    logic [3:0] tr = 4'h0;
    ssl_hi_ctl_s hc = '0;
    ssl_lo_ctl_s lc = '0;
    logic hf, lf, lp, slow, wd, por, irq, cfg, es;
    ssl_state_e hs, hm, ls, lm;
    int failures = 0, samples_checked = 0, seed = 32'h8cae, n, i;
    ssl_supervisor_ctl #(.FAST_CYC(4), .SLOW_CYC(20), .WAKE_CYC(20)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_hi_wr(hw), .i_hi_ctl(hc), .i_lo_wr(lw), .i_lo_ctl(lc), .i_lowpower(lp), .i_wake_req(wk),
        .i_hi_sup_trip(tr[3]), .i_hi_mon_trip(tr[2]), .i_lo_sup_trip(tr[1]), .i_lo_mon_trip(tr[0]),
        .o_hi_settle_delay_flag(hf), .o_lo_settle_delay_flag(lf), .o_hi_sup_state(hs), .o_hi_mon_state(hm),
        .o_lo_sup_state(ls), .o_lo_mon_state(lm), .o_slow_wakeup(slow), .o_wake_done(wd), .o_por(por),
        .o_lo_irq(irq), .o_affected_config_check(cfg));
    ssl_fw_model fw (.i_clk(i_clk), .i_enter_req(ent), .i_hi_flag(hf), .i_lo_flag(lf), .o_lowpower(lp));
    initial forever #2.5 i_clk = ~i_clk;
    // one decode serves every unit; the low monitor passes keep as 1, the high monitor passes the inverted auto bit
    function automatic ssl_state_e est(logic en, logic keep, logic fp, logic au, logic l);
        if (!en) return SSL_OFF;
        if (!l) return fp ? SSL_FULL : SSL_NORMAL;
        if (au) return (keep & fp) ? SSL_NORMAL : SSL_OFF;
        return keep ? (fp ? SSL_FULL : SSL_NORMAL) : SSL_OFF;
    endfunction : est
    function automatic logic echk(ssl_hi_ctl_s h, ssl_lo_ctl_s l);
        if (!(!l.sup_en || l.sup_fp || !l.mon_en || l.mon_fp)) return 1'b0;
        return (h.sup_en & ~h.sup_fp & (~h.sup_keep | h.auto_ctl)) | (h.mon_en & ~h.mon_fp & h.auto_ctl);
    endfunction : echk
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk);
    endtask : cyc
    // hang guard: the whole sequence needs well under a tenth of this
    initial begin
        #400us;
        failures++;
        tally_and_finish();
    end
    initial begin
        cyc(16);
        i_rst_n = 1'b1;
        cyc(2);
        for (i = 0; i < 60; i++) begin
            hc = ssl_hi_ctl_s'(7'($random(seed)));
            lc = ssl_lo_ctl_s'(7'($random(seed)));
            if (i < 2) lc = ssl_lo_ctl_s'({1'b0, 2'b11, i[0], 3'b000}); // corner: both lo perf settings
            if (i == 2) hc = ssl_hi_ctl_s'({1'b0, 3'b111, 3'b100}); // corner: high side manual, forced on
            hw = 1'b1;
            lw = 1'b1;
            cyc(1);
            hw = 1'b0;
            lw = 1'b0;
            cyc(1);
            chk({hf, lf}, 8'h3);
            cyc(5);
            chk({hf, lf}, {~hc.sup_fp, ~lc.sup_fp});
            ent = 1'($random(seed));
            cyc(30);
            chk(hs, est(hc.sup_en, hc.sup_keep, hc.sup_fp, hc.auto_ctl, ent));
            chk(hm, est(hc.mon_en, ~hc.auto_ctl, hc.mon_fp, hc.auto_ctl, ent));
            chk(ls, est(lc.sup_en, lc.sup_keep, lc.sup_fp, lc.auto_ctl, ent));
            chk(lm, est(lc.mon_en, 1'b1, lc.mon_fp, lc.auto_ctl, ent));
            chk(cfg, echk(hc, lc));
            es = (lc.sup_en & ~lc.sup_fp) | (lc.mon_en & ~lc.mon_fp);
            chk(slow, es);
            wk = 1'b1;
            cyc(1);
            wk = 1'b0;
            n = 0;
            // firmware holds servicing until the wake has completed
            while (wd !== 1'b1 && n < 100) begin
                cyc(1);
                n++;
            end
            chk(n[7:0], es ? 8'd20 : 8'd0);
            ent = 1'b0;
            cyc(3);
            tr = 4'($random(seed));
            cyc(3);
            chk(por, (tr[3] & (hc.sup_en === 1'b1)) | (tr[2] & hc.overvolt_en & hc.mon_en)
                | (|(tr[1:0] & {lc.sup_en, lc.mon_en}) & lc.ev_reset));
            chk(irq, |(tr[1:0] & {lc.sup_en, lc.mon_en}) & ~lc.ev_reset);
            tr = 4'h0;
            cyc(3);
        end
        tally_and_finish();
    end
endmodule : supply_supervisor_lowpower_control_tb_top
`default_nettype wire
